// ---- hdl/branch_stack_pointer_exec.sv ----
// executes zero branch, push, pointer subtract and subtract-and-return
`timescale 1ns/1ps
`include "branch_stack_defs.svh"
module branch_stack_pointer_exec
	import branch_stack_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_instr_valid,
	input wire logic [15:0] i_instr,
	input wire logic i_zero_flag,
	output logic o_instr_ready,
	output pc_t o_pc,
	output pc_t o_return_stack_top,
	output ptr_t o_indirect_pointer_reg0,
	output ptr_t o_indirect_pointer_reg1,
	output ptr_t o_pointer_reg_two
);
	stack_if stk ();

	////////////////////////////////////////////////////////////////
	// return stack storage
	return_stack u_stack (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.stk(stk)
	);

	////////////////////////////////////////////////////////////////
	// decoded instruction classes
	typedef enum logic [2:0] {
		CLS_SEQ = 3'b000,
		CLS_BRANCH = 3'b001,
		CLS_PUSH = 3'b010,
		CLS_SUB = 3'b011,
		CLS_SUB_RET = 3'b100
	} instr_class_e;

	////////////////////////////////////////////////////////////////
	// registers
	exec_state_e state_reg;
	pc_t pc_reg;
	ptr_t ptr_reg [0:2];

	////////////////////////////////////////////////////////////////
	// decode and control signals
	logic [7:0] opc;
	logic [1:0] sel;
	logic [5:0] lit;
	ptr_t lit_ext;
	instr_class_e cls;

	logic go;
	logic is_branch;
	logic is_push;
	logic is_sub;
	logic is_sub_ret;
	logic branch_taken;
	logic two_cycle;

	pc_t pc_inc;
	pc_t br_off;
	pc_t br_target;
	pc_t ret_target;

	////////////////////////////////////////////////////////////////
	// twice the signed 8-bit offset, widened to the pc
	function automatic pc_t branch_offset(input logic [7:0] offset);
		pc_t wide;
		wide = {{12{offset[7]}}, offset, 1'b0};
		return wide;
	endfunction : branch_offset

	////////////////////////////////////////////////////////////////
	// instruction word fields
	assign opc = i_instr[15:8];
	assign sel = i_instr[7:6];
	assign lit = i_instr[5:0];
	assign lit_ext = {6'h00, lit};

	////////////////////////////////////////////////////////////////
	// instruction class; any other word only steps the pc
	always_comb begin
		cls = CLS_SEQ;
		case (opc)
			`OPC_BRANCH_ZERO: begin
				cls = CLS_BRANCH;
			end
			`OPC_PTR_SUB: begin
				if (sel == `SEL_RETURN_FORM) begin
					cls = CLS_SUB_RET;
				end else begin
					cls = CLS_SUB;
				end
			end
			default: begin
				if (i_instr == `OPC_PUSH) begin
					cls = CLS_PUSH;
				end else begin
					cls = CLS_SEQ;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// acceptance; nothing is taken in an idle second cycle
	assign go = i_instr_valid && state_reg == EXEC_RUN;
	assign is_branch = go && cls == CLS_BRANCH;
	assign is_push = go && cls == CLS_PUSH;
	assign is_sub = go && cls == CLS_SUB;
	assign is_sub_ret = go && cls == CLS_SUB_RET;
	assign branch_taken = is_branch && i_zero_flag;
	assign two_cycle = branch_taken || is_sub_ret;

	////////////////////////////////////////////////////////////////
	// program counter targets
	assign pc_inc = pc_reg + `PC_STEP;
	assign br_off = branch_offset(i_instr[7:0]);
	assign br_target = pc_inc + br_off;
	assign ret_target = stk.top;

	////////////////////////////////////////////////////////////////
	// return stack requests
	assign stk.push = is_push;
	assign stk.push_data = pc_inc;
	assign stk.pop = is_sub_ret;

	////////////////////////////////////////////////////////////////
	// outputs
	assign o_instr_ready = state_reg == EXEC_RUN;
	assign o_pc = pc_reg;
	assign o_return_stack_top = stk.top;

	assign o_indirect_pointer_reg0 = ptr_reg[0];
	assign o_indirect_pointer_reg1 = ptr_reg[1];
	assign o_pointer_reg_two = ptr_reg[2];

	////////////////////////////////////////////////////////////////
	// second-cycle idle for taken branch and subtract-and-return
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			state_reg <= EXEC_RUN;
		end else begin
			case (state_reg)
				EXEC_RUN: begin
					if (two_cycle) begin
						state_reg <= EXEC_IDLE;
					end
				end
				EXEC_IDLE: begin
					state_reg <= EXEC_RUN;
				end
				default: begin
					state_reg <= EXEC_RUN;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// program counter; held while idle or without a valid word
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			pc_reg <= `PC_RESET;
		end else if (go) begin
			case (cls)
				CLS_BRANCH: begin
					if (i_zero_flag) begin
						pc_reg <= br_target;
					end else begin
						pc_reg <= pc_inc;
					end
				end
				CLS_SUB_RET: begin
					pc_reg <= ret_target;
				end
				default: begin
					pc_reg <= pc_inc;
				end
			endcase
		end else begin
			pc_reg <= pc_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// indirect pointers, one per select value 0 to 2, with value 3 also hitting pointer two; no status flag is touched
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_ptr
			logic hit;

			if (g == 2) begin : g_two
				assign hit = (is_sub && sel == 2'(g)) || is_sub_ret;
			end else begin : g_low
				assign hit = is_sub && sel == 2'(g);
			end

			always_ff @(posedge i_core_clk) begin
				if (i_srst) begin
					ptr_reg[g] <= `PTR_RESET;
				end else if (hit) begin
					ptr_reg[g] <= ptr_reg[g] - lit_ext;
				end
			end
		end
	endgenerate
endmodule : branch_stack_pointer_exec

// ---- shared/branch_stack_defs.svh ----
// constants for the branch, return stack and pointer execution block
// What this block does
// - zero set: pc gets pc plus two plus twice offset
// - push stores pc plus two as new top
// - subtract six-bit literal from chosen pointer, flags unchanged
// - combined form subtracts literal from pointer two
// - combined form then loads pc from stack top
// - combined form takes two cycles, second idle
// - select field binary 11 means combined form
`ifndef BRANCH_STACK_DEFS_SVH
`define BRANCH_STACK_DEFS_SVH
`define OPC_BRANCH_ZERO 8'he0
`define OPC_PTR_SUB 8'he9
`define OPC_PUSH 16'h0005
`define SEL_RETURN_FORM 2'h3
`define PC_STEP 21'h000002
`define PC_RESET 21'h000000
`define PTR_RESET 12'h000
`define STACK_DEPTH 31
`define STACK_PTR_W 5
`define STACK_PTR_MAX 5'h1f
`endif

// ---- shared/branch_stack_pkg.sv ----
// types for the branch, return stack and pointer execution block
package branch_stack_pkg;
	typedef logic [20:0] pc_t;
	typedef logic [11:0] ptr_t;
	typedef enum logic [0:0] {
		EXEC_RUN = 1'b0,
		EXEC_IDLE = 1'b1
	} exec_state_e;
endpackage : branch_stack_pkg

// ---- shared/stack_if.sv ----
// push and pop carrier between the executor and the return stack
`timescale 1ns/1ps
interface stack_if;
	import branch_stack_pkg::*;
	logic push;
	logic pop;
	pc_t push_data;
	pc_t top;
	modport exec (output push, output pop, output push_data, input top);
	modport store (input push, input pop, input push_data, output top);
endinterface : stack_if

// ---- hdl/return_stack.sv ----
// hardware return stack memory with registered top entry
`timescale 1ns/1ps
`include "branch_stack_defs.svh"
module return_stack
	import branch_stack_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_srst,
	stack_if.store stk
);
	pc_t mem [0:`STACK_DEPTH];
	logic [`STACK_PTR_W-1:0] depth_reg;
	pc_t top_reg;
	assign stk.top = top_reg;
	////////////////////////////////////////////////////////////////
	// stack level counter
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			depth_reg <= '0;
		end else if (stk.push && depth_reg != `STACK_PTR_MAX) begin
			depth_reg <= depth_reg + 5'h01;
		end else if (stk.pop && !stk.push && depth_reg != '0) begin
			depth_reg <= depth_reg - 5'h01;
		end
	end
	////////////////////////////////////////////////////////////////
	// entries; old top moves one level down on push
	always_ff @(posedge i_core_clk) begin
		if (stk.push) begin
			mem[depth_reg] <= top_reg;
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			top_reg <= `PC_RESET;
		end else if (stk.push) begin
			top_reg <= stk.push_data;
		end else if (stk.pop) begin
			top_reg <= (depth_reg != '0) ? mem[depth_reg - 5'h01] : `PC_RESET;
		end
	end
endmodule : return_stack

// ---- bench/exec_sva.sv ----
// assertions on the executor ports
`timescale 1ns/1ps
module exec_sva
	import branch_stack_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_instr_valid,
	input wire logic [15:0] i_instr,
	input wire logic i_zero_flag,
	input wire logic o_instr_ready,
	input wire pc_t o_pc,
	input wire pc_t o_return_stack_top,
	input wire ptr_t o_indirect_pointer_reg0,
	input wire ptr_t o_indirect_pointer_reg1,
	input wire ptr_t o_pointer_reg_two
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_srst);
	wire logic acc = i_instr_valid && o_instr_ready;
	wire logic br = acc && i_instr[15:8] == 8'he0;
	wire logic sub = acc && i_instr[15:8] == 8'he9;
	wire logic ret = sub && i_instr[7:6] == 2'h3;
	wire logic [11:0] k = {6'h0, i_instr[5:0]};
	AST_BR_TAKEN: assert property (br && i_zero_flag |=>
		o_pc == $past(o_pc + 21'h2 + {{12{i_instr[7]}}, i_instr[7:0], 1'b0})) else $error("branch pc");
	AST_BR_IDLE: assert property (br && i_zero_flag |=>
		!o_instr_ready ##1 (o_instr_ready && $stable(o_pc))) else $error("branch idle");
	AST_BR_SEQ: assert property (br && !i_zero_flag |=>
		o_instr_ready && o_pc == $past(o_pc) + 21'h2) else $error("branch fall through");
	AST_PUSH: assert property (acc && i_instr == 16'h0005 |=>
		o_return_stack_top == $past(o_pc) + 21'h2) else $error("push top");
	AST_SUB_ONE: assert property (sub && i_instr[7:6] == 2'h1 |=>
		o_indirect_pointer_reg1 == $past(o_indirect_pointer_reg1 - k) && $stable(o_pointer_reg_two)) else $error("sub");
	AST_RET_PTR: assert property (ret |=>
		o_pointer_reg_two == $past(o_pointer_reg_two - k) && $stable(o_indirect_pointer_reg0)) else $error("ret ptr");
	AST_RET_PC: assert property (ret |=> o_pc == $past(o_return_stack_top)) else $error("ret pc");
	AST_RET_IDLE: assert property (ret |=>
		!o_instr_ready ##1 (o_instr_ready && $stable(o_pc))) else $error("ret idle");
endmodule : exec_sva
bind branch_stack_pointer_exec exec_sva chk (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_instr_valid(i_instr_valid),
	.i_instr(i_instr), .i_zero_flag(i_zero_flag), .o_instr_ready(o_instr_ready), .o_pc(o_pc),
	.o_return_stack_top(o_return_stack_top), .o_indirect_pointer_reg0(o_indirect_pointer_reg0),
	.o_indirect_pointer_reg1(o_indirect_pointer_reg1), .o_pointer_reg_two(o_pointer_reg_two));

// ---- bench/branch_stack_pointer_exec_tb_top.sv ----
// random self-checking bench for the executor
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s %h %h", n, e, g); end end
module branch_stack_pointer_exec_tb_top
	import branch_stack_pkg::*;
;
	logic i_core_clk = 1'b0, i_srst = 1'b1, i_instr_valid = 1'b0, i_zero_flag = 1'b0, o_instr_ready;
	logic [15:0] i_instr = 16'h0;
	pc_t o_pc, o_return_stack_top;
	ptr_t o_indirect_pointer_reg0, o_indirect_pointer_reg1, o_pointer_reg_two;
	int errors = 0, checked = 0, mpc = 0, k, p[3] = '{0, 0, 0}, stk[$];
	bit mrdy = 1;
	logic [31:0] r = 32'h8994;
	always #4 i_core_clk = ~i_core_clk;
	branch_stack_pointer_exec uut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_instr_valid(i_instr_valid),
		.i_instr(i_instr), .i_zero_flag(i_zero_flag), .o_instr_ready(o_instr_ready), .o_pc(o_pc),
		.o_return_stack_top(o_return_stack_top), .o_indirect_pointer_reg0(o_indirect_pointer_reg0),
		.o_indirect_pointer_reg1(o_indirect_pointer_reg1), .o_pointer_reg_two(o_pointer_reg_two));
	task end_of_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next
	task step;
		mpc += 2;
		if (i_instr[15:8] == 8'he0 && i_zero_flag) begin
			mpc += 2 * int'($signed(i_instr[7:0]));
			mrdy = 0;
		end
		if (i_instr == 16'h0005) stk.push_front(mpc);
		if (i_instr[15:8] == 8'he9) begin
			k = i_instr[7:6] == 2'h3 ? 2 : i_instr[7:6];
			p[k] -= i_instr[5:0];
			if (k == 2 && i_instr[6]) begin
				mpc = stk.size() ? stk.pop_front() : 0;
				mrdy = 0;
			end
		end
		if (stk.size() > 32) stk.pop_back();
	endtask : step
	initial begin
		repeat (20) @(negedge i_core_clk);
		i_srst = 0;
		for (int n = 0; n < 600; n++) begin
			@(negedge i_core_clk);
			`CHK("rdy", mrdy, o_instr_ready)
			`CHK("pc", pc_t'(mpc), o_pc)
			`CHK("top", pc_t'(stk.size() ? stk[0] : 0), o_return_stack_top)
			`CHK("p0", ptr_t'(p[0]), o_indirect_pointer_reg0)
			`CHK("p1", ptr_t'(p[1]), o_indirect_pointer_reg1)
			`CHK("p2", ptr_t'(p[2]), o_pointer_reg_two)
			r = lfsr_next(r);
			i_zero_flag = r[3];
			i_instr_valid = r[4] | r[5];
			i_instr = r[2:0] == 3'h0 ? {8'he0, r[15:8]} : r[2:0] == 3'h1 ? r[23:8] :
				r[2:0] == 3'h2 ? 16'h0005 : {8'he9, r[15:8]};
			if (!mrdy) mrdy = 1;
			else if (i_instr_valid) step();
		end
		$display("random test done");
		end_of_test();
	end
endmodule : branch_stack_pointer_exec_tb_top
